// ===== core/fdi_consts.vh
// Purpose: Constants for the diskette drive interface logic
// Assumes: 100 MHz clock, cable signals active low except density select (high = high density)
// Notes:   Timing figures in microseconds, counts derived from them
`ifndef FDI_CONSTS_VH
`define FDI_CONSTS_VH
`define FDI_CLK_MHZ        100
`define FDI_TRK_TIME_US    3000
`define FDI_SETTLE_US      15000
`define FDI_ROT_US         166700
`define FDI_INDEX_US       200
`define FDI_PWRON_US       1000
`define FDI_NUM_UNITS      4
`define FDI_LAST_TRACK     79
`define FDI_TRACK_ZERO     7'h00
`define FDI_ACTIVE         1'b0
`define FDI_INACTIVE       1'b1
`endif

// ===== core/fdi_drive.v
// Purpose: Drive-side logic of a 34-way diskette drive cable interface
// Assumes: Media sensors and mechanism are simple inputs and outputs
// Notes:   Open-collector outputs as level plus output enable
`timescale 1ns/1ps
`include "fdi_consts.vh"

// Behaviour
// - Low level means asserted on every line except density select, where high means high density
// - Only the selected unit's lines are active
// - Motor low with diskette starts spindle
// - Direction high outward, low inward
// - One cylinder per step pulse
// - Falling write edge reverses head current
// - Write only while gate is low
// - Side select high side 0, low side 1
// - One index mark per rotation
// - Track zero flag low on track 00
// - Protected diskette reports and blocks writes
// - Read data pulses low from head
// - Media changed warns of removed diskette
// - Jumper picks head-load meaning of input
// - Density follows density select level
// - Own power-on reset, safe power cycles
// - Up to four drives share cable
// - Head load on input or motor, jumpered
module fdi_drive #(
  parameter integer TRK_CYC    = `FDI_TRK_TIME_US * `FDI_CLK_MHZ,
  parameter integer ROT_CYC    = `FDI_ROT_US * `FDI_CLK_MHZ,
  parameter integer INDEX_CYC  = `FDI_INDEX_US * `FDI_CLK_MHZ,
  parameter integer PWRON_CYC  = `FDI_PWRON_US * `FDI_CLK_MHZ,
  parameter [1:0]   UNIT_ID    = 2'h0,
  parameter [6:0]   LAST_TRACK = `FDI_LAST_TRACK
) (
  input  wire       clk,
  input  wire       reset_n,
  // Cable inputs, active low except density_select, where high selects high density
  input  wire [3:0] unit_select_lines_n,
  input  wire       spindle_motor_on_n,
  input  wire       head_direction,
  input  wire       step_pulse_n,
  input  wire       write_flux_n,
  input  wire       write_enable_gate_n,
  input  wire       head_side_select,
  input  wire       head_load_in_use_n,
  input  wire       density_select,
  // Cable outputs, open collector
  output reg        index_mark_o,
  output wire       index_mark_oe,
  output reg        track_zero_flag_o,
  output wire       track_zero_flag_oe,
  output reg        write_protected_flag_o,
  output wire       write_protected_flag_oe,
  output reg        read_flux_o,
  output wire       read_flux_oe,
  output reg        media_changed_flag_o,
  output wire       media_changed_flag_oe,
  // Jumpers and media sensors
  input  wire       jmp_head_load_mode,
  input  wire       jmp_load_on_motor,
  input  wire       disk_present,
  input  wire       notch_covered,
  input  wire       head_flux_pulse,
  // Mechanism controls
  output reg        spindle_on,
  output reg        head_loaded,
  output reg        head_select_side1,
  output reg        write_current_dir,
  output reg        write_active,
  output reg        high_density,
  output reg  [6:0] cylinder,
  output reg        step_busy
);

  localparam integer NIN = 10;
  // Bit map of the filtered vector f_q:
  //   0 motor request, 1 step, 2 write flux, 3 write gate,
  //   4 side, 5 density, 6 head load, 7 read flux sensor,
  //   8 protect sensor, 9 disk present
  // Everything from outside the clock is asynchronous, so each
  // bit gets three flops; the agree stage rejects a single
  // sampled glitch at the cost of one more cycle of latency.

  // Three-stage synchronisers for all cable and sensor inputs
  wire [NIN-1:0] raw_in = {disk_present, notch_covered, head_flux_pulse,
                           head_load_in_use_n, density_select,
                           head_side_select, write_enable_gate_n,
                           write_flux_n, step_pulse_n,
                           spindle_motor_on_n};
  reg [NIN-1:0] s1_q;
  reg [NIN-1:0] s2_q;
  reg [NIN-1:0] s3_q;
  reg [NIN-1:0] f_q;
  reg [3:0] sel1_q;
  reg [3:0] sel2_q;
  reg [3:0] sel3_q;
  reg       dir1_q;
  reg       dir2_q;
  reg       dir3_q;
  reg [3:0] sel_f_q;
  reg       dir_f_q;
  genvar gi;

  // All stages reset to the released level so that no false step or
  // write flux edge is seen on the first cycles after reset.
  // Filtered value moves only when stages two and three agree
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
          f_q[gi]  <= 1'b1;
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            f_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  // The select bus is filtered as a word; a change on several lines
  // at once lands in one cycle, so two units never look selected.
  // Direction must be settled before the step edge reaches f_q.
  // Both registers reset to the released level as well.
  // Select lines and direction through the same three stages
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel1_q  <= 4'hF;
      sel2_q  <= 4'hF;
      sel3_q  <= 4'hF;
      sel_f_q <= 4'hF;
      dir1_q  <= 1'b1;
      dir2_q  <= 1'b1;
      dir3_q  <= 1'b1;
      dir_f_q <= 1'b1;
    end else begin
      sel1_q <= unit_select_lines_n;
      sel2_q <= sel1_q;
      sel3_q <= sel2_q;
      dir1_q <= head_direction;
      dir2_q <= dir1_q;
      dir3_q <= dir2_q;
      if (sel2_q == sel3_q)
        sel_f_q <= sel3_q;
      if (dir2_q == dir3_q)
        dir_f_q <= dir3_q;
    end
  end

  // Decoded requests, true when the cable line is low
  wire motor_req  = (f_q[0] == `FDI_ACTIVE);
  wire step_n     = f_q[1];
  wire wflux_n    = f_q[2];
  wire wgate      = (f_q[3] == `FDI_ACTIVE);
  wire side_sel   = f_q[4];
  wire dens       = f_q[5];
  wire hld_req    = (f_q[6] == `FDI_ACTIVE);
  wire flux_in    = f_q[7];
  wire protect    = f_q[8];
  wire present    = f_q[9];
  // This unit answers only on its own select line
  wire selected   = (sel_f_q[UNIT_ID] == `FDI_ACTIVE);

  // The counter stops once done, so it never wraps back to zero.
  // Until then no step, write or spindle start is accepted, which
  // keeps a power cycle from disturbing the recorded tracks.
  // Counter width covers the default hold with room to spare.
  // Power-on hold-off: mechanism idle until the counter expires
  reg [31:0] por_cnt_q;
  reg        por_done_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      por_cnt_q  <= 32'h0;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      por_cnt_q <= por_cnt_q + 32'h1;
      if (por_cnt_q >= PWRON_CYC - 1)
        por_done_q <= 1'b1;
    end
  end

  // Only falling edges carry meaning on step and write flux.
  // present_prev_q starts low, but present resets high with f_q, so a
  // missing diskette at power up shows in the absence term and as a removal.
  // Each detector compares the filtered value with one cycle ago.
  // Edge detectors on filtered step and write flux
  reg step_prev_q;
  reg wflux_prev_q;
  reg present_prev_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_prev_q    <= 1'b1;
      wflux_prev_q   <= 1'b1;
      present_prev_q <= 1'b0;
    end else begin
      step_prev_q    <= step_n;
      wflux_prev_q   <= wflux_n;
      present_prev_q <= present;
    end
  end
  wire step_fall  = step_prev_q & ~step_n;
  wire wflux_fall = wflux_prev_q & ~wflux_n;
  wire removed    = present_prev_q & ~present;

  // The spindle follows the motor line even when unselected, as
  // all units on the cable share it. Head load needs select.
  // Side and density are plain levels taken after the filter.
  // Spindle, head load, side, density
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      spindle_on        <= 1'b0;
      head_loaded       <= 1'b0;
      head_select_side1 <= 1'b0;
      high_density      <= 1'b0;
    end else begin
      spindle_on <= por_done_q & motor_req & present;
      if (jmp_load_on_motor)
        head_loaded <= por_done_q & selected & motor_req;
      else
        head_loaded <= por_done_q & selected & jmp_head_load_mode
                       & hld_req;
      if (selected)
        head_select_side1 <= ~side_sel;
      high_density <= dens;
    end
  end

  // A step inside the busy window is dropped, not queued: the
  // controller is expected to space its pulses. At the crash
  // stops the step is accepted but the cylinder stays put.
  // Direction high moves outward, toward cylinder zero.
  // Stepper: one cylinder per falling step edge, stops at the ends
  reg [31:0] trk_cnt_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cylinder  <= `FDI_TRACK_ZERO;
      step_busy <= 1'b0;
      trk_cnt_q <= 32'h0;
    end else if (step_busy) begin
      if (trk_cnt_q >= TRK_CYC - 1)
        step_busy <= 1'b0;
      trk_cnt_q <= trk_cnt_q + 32'h1;
    end else if (selected & step_fall & por_done_q) begin
      step_busy <= 1'b1;
      trk_cnt_q <= 32'h0;
      if (dir_f_q) begin
        if (cylinder != `FDI_TRACK_ZERO)
          cylinder <= cylinder - 7'h01;
      end else if (cylinder != LAST_TRACK)
        cylinder <= cylinder + 7'h01;
    end
  end

  // write_active drops in the cycle after any qualifier falls, so
  // a protect notch or a removed diskette ends a write at once.
  // The current only toggles while writing is allowed.
  // Write path: gated by select, gate and protect
  wire wr_ok = selected & wgate & ~protect & present & por_done_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_active      <= 1'b0;
      write_current_dir <= 1'b0;
    end else begin
      write_active <= wr_ok;
      if (wr_ok & wflux_fall)
        write_current_dir <= ~write_current_dir;
    end
  end

  // The rotation counter restarts with the spindle, so the first
  // index mark follows a spin-up within one revolution.
  // The mark is asserted for INDEX_CYC cycles of every ROT_CYC.
  // Index generator, running while the spindle turns
  reg [31:0] rot_cnt_q;
  reg        index_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rot_cnt_q <= 32'h0;
      index_q   <= 1'b0;
    end else if (!spindle_on) begin
      rot_cnt_q <= 32'h0;
      index_q   <= 1'b0;
    end else begin
      if (rot_cnt_q >= ROT_CYC - 1)
        rot_cnt_q <= 32'h0;
      else
        rot_cnt_q <= rot_cnt_q + 32'h1;
      index_q <= (rot_cnt_q < INDEX_CYC);
    end
  end

  // Absence keeps the flag set, and the set term is tested first,
  // so it wins over a clearing step in the same cycle.
  // Changed flag: set on removal, cleared by a step with disk in
  reg changed_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      changed_q <= 1'b1;
    end else if (removed | ~present) begin
      changed_q <= 1'b1;
    end else if (selected & step_fall) begin
      changed_q <= 1'b0;
    end
  end

  // Every cable output is registered to keep glitches off the
  // shared lines; each one is gated by select so that a second
  // drive on the cable never sees two drivers at once.
  // Cable outputs: low when asserted and selected, else released
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      index_mark_o           <= `FDI_INACTIVE;
      track_zero_flag_o      <= `FDI_INACTIVE;
      write_protected_flag_o <= `FDI_INACTIVE;
      read_flux_o            <= `FDI_INACTIVE;
      media_changed_flag_o   <= `FDI_INACTIVE;
    end else begin
      index_mark_o      <= ~(selected & index_q);
      track_zero_flag_o <= ~(selected &
                             (cylinder == `FDI_TRACK_ZERO));
      write_protected_flag_o <= ~(selected & protect);
      read_flux_o <= ~(selected & head_loaded & ~wgate
                       & flux_in);
      media_changed_flag_o <= ~(selected & changed_q);
    end
  end

  // The enable is high exactly while the level is low, giving
  // open-collector behaviour without a high-impedance value.
  // Open collector: enable only while pulling low
  assign index_mark_oe           = ~index_mark_o;
  assign track_zero_flag_oe      = ~track_zero_flag_o;
  assign write_protected_flag_oe = ~write_protected_flag_o;
  assign read_flux_oe            = ~read_flux_o;
  assign media_changed_flag_oe   = ~media_changed_flag_o;

  // Limitations: no settle timer after a seek, no speed ramp, and
  // the read flux sensor is passed through without data separation.
  // These belong to the mechanism side, outside this block.

endmodule // fdi_drive

// ===== bench/fdi_drive_monitor.sv
// Purpose: Port checker for the drive
// Assumes: Inputs settle within 8 clocks
// Notes:   Bound from the testbench
`timescale 1ns/1ps
module fdi_drive_monitor #(
  parameter [1:0] UNIT_ID = 2'h0
) (
  input wire       clk,
  input wire       reset_n,
  input wire [3:0] unit_select_lines_n,
  input wire       head_direction,
  input wire       write_enable_gate_n,
  input wire       head_side_select,
  input wire       density_select,
  input wire       notch_covered,
  input wire       index_mark_o,
  input wire       track_zero_flag_o,
  input wire       write_protected_flag_o,
  input wire       read_flux_o,
  input wire       media_changed_flag_o,
  input wire       head_select_side1,
  input wire       write_active,
  input wire       high_density,
  input wire [6:0] cylinder,
  input wire       step_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire sel_n = unit_select_lines_n[UNIT_ID];
  // Selection held long enough to pass the input filter
  sequence s_off; sel_n [*8]; endsequence
  sequence s_on; !sel_n [*8]; endsequence
  a_unsel_released:
    assert property (s_off |-> &{index_mark_o, track_zero_flag_o,
      write_protected_flag_o, read_flux_o, media_changed_flag_o})
      else $error("unselected drive pulls a line");
  a_trk0_level:
    assert property (s_on ##0 $stable(cylinder) ##0
      (cylinder == $past(cylinder, 2)) |->
      track_zero_flag_o == (cylinder != 7'h00)) else $error("track zero");
  a_step_one:
    assert property ($changed(cylinder) |-> cylinder == (head_direction ?
      $past(cylinder) - 7'h01 : $past(cylinder) + 7'h01))
      else $error("bad step");
  a_step_busy:
    assert property ($changed(cylinder) |-> $rose(step_busy))
      else $error("step without busy");
  a_density_level:
    assert property ($stable(density_select) [*8] |->
      high_density == density_select) else $error("density");
  a_side_level:
    assert property ($stable(head_side_select) [*8] |->
      head_select_side1 == !head_side_select) else $error("side");
  a_gate_read:
    assert property (write_enable_gate_n [*8] |-> !write_active)
      else $error("write without gate");
  a_protect_block:
    assert property (notch_covered [*8] |-> !write_active)
      else $error("write when protected");
endmodule // fdi_drive_monitor

// ===== bench/fdi_ctrl_model.sv
// Purpose: Controller model issuing head steps
// Assumes: One step at a time from the bench
// Notes:   Short gaps only provoke a refused step
`timescale 1ns/1ps
module fdi_ctrl_model (
  input  wire clk,
  output reg  step_pulse_n,
  output reg  head_direction
);
  // Idle levels
  initial begin
    step_pulse_n   = 1'b1;
    head_direction = 1'b1;
  end
  // Direction held steady around a low step pulse
  task automatic step(input reg dir, input integer gap);
    begin
      @(negedge clk) head_direction = dir;
      repeat (8) @(negedge clk);
      step_pulse_n = 1'b0;
      repeat (4) @(negedge clk);
      step_pulse_n = 1'b1;
      repeat (gap) @(negedge clk);
    end
  endtask
endmodule // fdi_ctrl_model

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the drive
// Assumes: Unit 0, short timing parameters
// Notes:   Seeded random steps among corner cases
`timescale 1ns/1ps
`define CHK(g, e, m) begin check_count = check_count + 1; \
  if ((g) !== (e)) begin fails = fails + 1; \
  $display("wrong value at %0t: %s", $time, m); end end
module testbench;
  localparam [6:0] LAST = 7'h05;
  reg         clk, reset_n, spindle_motor_on_n, write_flux_n, d, wd;
  reg         write_enable_gate_n, head_side_select, head_load_in_use_n;
  reg         jmp_head_load_mode, jmp_load_on_motor, disk_present;
  reg         notch_covered, head_flux_pulse, density_select;
  reg  [3:0]  unit_select_lines_n;
  reg  [6:0]  exp_cyl;
  reg  [31:0] r;
  wire        step_pulse_n, head_direction, index_mark_o, index_mark_oe;
  wire        track_zero_flag_o, track_zero_flag_oe, write_protected_flag_o;
  wire        write_protected_flag_oe, read_flux_o, read_flux_oe;
  wire        media_changed_flag_o, media_changed_flag_oe, spindle_on;
  wire        head_loaded, head_select_side1, write_current_dir;
  wire        write_active, high_density, step_busy;
  wire [6:0]  cylinder;
  integer     fails, check_count, seed, i, k;
  fdi_drive #(.TRK_CYC(20), .ROT_CYC(200), .INDEX_CYC(5), .PWRON_CYC(10),
    .LAST_TRACK(LAST)) i_dut (.*);
  fdi_ctrl_model i_ctrl (.*);
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function [6:0] next_cyl(input [6:0] c, input dir);
    next_cyl = dir ? ((c == 7'h00) ? c : c - 7'h01) :
      ((c == LAST) ? c : c + 7'h01);
  endfunction
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task print_verdict;
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #200000;
    fails = fails + 1;
    print_verdict;
  end
  // Main sequence
  initial begin
    fails = 0;
    check_count = 0;
    seed = 32'hD24F;
    {reset_n, jmp_load_on_motor, notch_covered, head_flux_pulse} = 4'h0;
    {spindle_motor_on_n, write_flux_n, write_enable_gate_n, head_side_select,
     head_load_in_use_n, density_select, jmp_head_load_mode,
     disk_present} = 8'hFF;
    unit_select_lines_n = 4'hE;
    wt(10);
    reset_n = 1'b1;
    wt(30);
    `CHK(cylinder, 7'h00, "reset cyl")
    `CHK(media_changed_flag_o, 1'b0, "change at reset")
    i_ctrl.step(1'b1, 30);
    `CHK(cylinder, 7'h00, "outer stop")
    i_ctrl.step(1'b0, 30);
    `CHK(media_changed_flag_o, 1'b1, "change cleared")
    exp_cyl = 7'h01;
    // Random steps with random density and side
    for (i = 0; i < 24; i = i + 1) begin
      r = $random(seed);
      d = r[0];
      density_select = r[1];
      head_side_select = r[2];
      i_ctrl.step(d, 30);
      exp_cyl = next_cyl(exp_cyl, d);
      `CHK(cylinder, exp_cyl, "cyl")
      `CHK(track_zero_flag_o, exp_cyl != 7'h00, "trk0")
      `CHK(high_density, density_select, "density")
      `CHK(head_select_side1, !head_side_select, "side")
    end
    // Second pulse inside busy time is ignored
    i_ctrl.step(1'b0, 2);
    i_ctrl.step(1'b0, 30);
    exp_cyl = next_cyl(exp_cyl, 1'b0);
    `CHK(cylinder, exp_cyl, "busy step")
    // Other unit selected: lines released, steps ignored
    unit_select_lines_n = 4'hD;
    i_ctrl.step(1'b1, 30);
    `CHK({index_mark_o, track_zero_flag_o, write_protected_flag_o,
      read_flux_o, media_changed_flag_o}, 5'h1F, "released")
    `CHK({index_mark_oe, track_zero_flag_oe, write_protected_flag_oe,
      read_flux_oe, media_changed_flag_oe}, 5'h00, "oe off")
    `CHK(cylinder, exp_cyl, "unselected")
    unit_select_lines_n = 4'hE;
    spindle_motor_on_n = 1'b0;
    wt(20);
    `CHK(spindle_on, 1'b1, "spindle")
    k = 0;
    d = index_mark_o;
    for (i = 0; i < 400; i = i + 1) begin
      wt(1);
      if (d && !index_mark_o) k = k + 1;
      d = index_mark_o;
    end
    `CHK(k, 2, "index count")
    // Head load by input, then by motor jumper
    head_load_in_use_n = 1'b0;
    wt(10);
    `CHK(head_loaded, 1'b1, "load input")
    head_load_in_use_n = 1'b1;
    jmp_load_on_motor = 1'b1;
    head_flux_pulse = 1'b1;
    wt(10);
    `CHK(head_loaded, 1'b1, "load motor")
    `CHK(read_flux_o, 1'b0, "read")
    head_flux_pulse = 1'b0;
    write_enable_gate_n = 1'b0;
    wt(10);
    `CHK(write_active, 1'b1, "gate")
    // Only falling write edges flip the current
    for (i = 0; i < 4; i = i + 1) begin
      wd = write_current_dir;
      write_flux_n = 1'b0;
      wt(8);
      write_flux_n = 1'b1;
      wt(8);
      `CHK(write_current_dir, !wd, "current")
    end
    notch_covered = 1'b1;
    wt(10);
    `CHK(write_active, 1'b0, "protected")
    `CHK(write_protected_flag_o, 1'b0, "prot flag")
    disk_present = 1'b0;
    wt(10);
    `CHK(media_changed_flag_o, 1'b0, "removed")
    `CHK(spindle_on, 1'b0, "no disk")
    print_verdict;
  end
endmodule // testbench
bind fdi_drive fdi_drive_monitor #(.UNIT_ID(UNIT_ID)) i_mon (.*);
